// >>> design/nvm_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_end
   import nvm_ctrl_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        memWrite,
   input  wire logic        memTargetEeprom,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memData,
   output logic             memRefused,
   output logic             irq,
   output logic             runPowerDown,
   nvm_link_if.ctrl         link
);
   logic [31:0] ctrl;
   logic [1:0]  ctrlKeyStep, codeKeyStep, optKeyStep, pdKeyStep;
   logic        ctrlStuck, codeStuck, optStuck, pdStuck;
   logic        pdUnlocked;
   logic        endFlag, errFlag;
   logic [5:0]  loads;
   logic        wrAccess;
   logic        keyErr;
   logic        idle;
   logic        ctrlLocked;
   logic        bulk;
   logic        needSel;
   logic [5:0]  loadTarget;

   assign wrAccess   = psel && penable && pwrite;
   assign idle       = !link.busy;
   assign ctrlLocked = ctrl[BIT_CONTROL_LOCK];
   assign pready     = 1'b1;
   assign bulk       = ctrl[BIT_BULK_LOAD];
   assign loadTarget = memTargetEeprom ? 6'(DOUBLE_WORD_LOADS) : 6'(HALF_PAGE_LOADS); // R6 R7

   // Key sequencing: bad value or third access sticks until reset
   function automatic logic key_bad(input logic [1:0]  step,
                                    input logic [31:0] d,
                                    input logic [31:0] k1,
                                    input logic [31:0] k2);
      return !((step == 2'h0 && d == k1) || (step == 2'h1 && d == k2));
   endfunction : key_bad

   always_comb begin
      keyErr = 1'b0;
      if (wrAccess) begin
         unique case (paddr)
            OFS_CONTROL_UNLOCK_KEY: keyErr = ctrlStuck ||
               key_bad(ctrlKeyStep, pwdata, CTRL_KEY1, CTRL_KEY2); // R15
            OFS_CODE_ARRAY_KEY: keyErr = ctrlLocked || codeStuck ||
               key_bad(codeKeyStep, pwdata, CODE_KEY1, CODE_KEY2); // R19
            OFS_OPTION_KEY: keyErr = ctrlLocked || optStuck ||
               key_bad(optKeyStep, pwdata, OPT_KEY1, OPT_KEY2); // R22
            OFS_POWER_DOWN_KEY: keyErr = pdStuck ||
               key_bad(pdKeyStep, pwdata, PD_KEY1, PD_KEY2);
            default: keyErr = 1'b0;
         endcase
      end
   end

   logic unmapped;
   always_comb begin
      unique case (paddr)
         OFS_ACCESS_CONTROL, OFS_PROGRAM_ERASE_CONTROL, OFS_POWER_DOWN_KEY,
         OFS_CONTROL_UNLOCK_KEY, OFS_CODE_ARRAY_KEY, OFS_OPTION_KEY, OFS_STATUS: unmapped = 1'b0;
         default: unmapped = 1'b1;
      endcase
   end
   assign pslverr = psel && penable && (keyErr || unmapped); // R15

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrlKeyStep <= '0;
         codeKeyStep <= '0;
         optKeyStep  <= '0;
         pdKeyStep   <= '0;
         ctrlStuck   <= 1'b0;
         codeStuck   <= 1'b0;
         optStuck    <= 1'b0;
         pdStuck     <= 1'b0;
      end else if (wrAccess) begin
         unique case (paddr)
            OFS_CONTROL_UNLOCK_KEY: begin
               if (keyErr) ctrlStuck <= 1'b1; // R15
               else ctrlKeyStep <= ctrlKeyStep + 2'd1; // R18
            end
            OFS_CODE_ARRAY_KEY: begin
               if (keyErr) codeStuck <= 1'b1;
               else codeKeyStep <= codeKeyStep + 2'd1; // R20
            end
            OFS_OPTION_KEY: begin
               if (keyErr) optStuck <= 1'b1;
               else optKeyStep <= optKeyStep + 2'd1; // R22
            end
            OFS_POWER_DOWN_KEY: begin
               if (keyErr) pdStuck <= 1'b1;
               else pdKeyStep <= pdKeyStep + 2'd1; // R21
            end
            default: ;
         endcase
      end
   end

   // Control register with locks, mode bits and launch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
      end else begin
         if (wrAccess && paddr == OFS_CONTROL_UNLOCK_KEY && !keyErr && ctrlKeyStep == 2'd1)
            ctrl[BIT_CONTROL_LOCK] <= 1'b0; // R14
         if (wrAccess && paddr == OFS_CODE_ARRAY_KEY && !keyErr && codeKeyStep == 2'd1)
            ctrl[BIT_CODE_LOCK] <= 1'b0; // R14
         if (wrAccess && paddr == OFS_OPTION_KEY && !keyErr && optKeyStep == 2'd1)
            ctrl[BIT_OPTION_LOCK] <= 1'b0; // R14
         if (wrAccess && paddr == OFS_PROGRAM_ERASE_CONTROL && !ctrlLocked) begin // R1
            ctrl[BIT_END_IE] <= pwdata[BIT_END_IE]; // R4
            ctrl[BIT_ERR_IE] <= pwdata[BIT_ERR_IE]; // R4
            if (pwdata[BIT_OPT_LAUNCH] && !ctrl[BIT_OPTION_LOCK])
               ctrl[BIT_OPT_LAUNCH] <= 1'b1; // R3
            if (idle) begin // R9
               ctrl[BIT_DUAL_BANK]     <= pwdata[BIT_DUAL_BANK];
               ctrl[BIT_BULK_LOAD]     <= pwdata[BIT_BULK_LOAD];
               ctrl[BIT_ERASE]         <= pwdata[BIT_ERASE];
               ctrl[BIT_FIXED_TIME]    <= pwdata[BIT_FIXED_TIME];
               ctrl[BIT_EEPROM_SELECT] <= pwdata[BIT_EEPROM_SELECT];
               ctrl[BIT_CODE_SELECT]   <= pwdata[BIT_CODE_SELECT];
            end
            if (pwdata[BIT_CODE_LOCK]) ctrl[BIT_CODE_LOCK] <= 1'b1; // R14
            if (pwdata[BIT_OPTION_LOCK]) ctrl[BIT_OPTION_LOCK] <= 1'b1; // R14
            if (pwdata[BIT_CONTROL_LOCK]) begin
               ctrl[BIT_CONTROL_LOCK]  <= 1'b1; // R14
               ctrl[BIT_CODE_LOCK]     <= 1'b1; // R16
               ctrl[BIT_OPTION_LOCK]   <= 1'b1; // R16
               ctrl[BIT_BULK_LOAD]     <= 1'b0; // R10
               ctrl[BIT_ERASE]         <= 1'b0; // R10
               ctrl[BIT_FIXED_TIME]    <= 1'b0; // R10
               ctrl[BIT_EEPROM_SELECT] <= 1'b0; // R10
               ctrl[BIT_CODE_SELECT]   <= 1'b0; // R10
            end
         end
         if (link.optLoadDone) ctrl[BIT_OPT_LAUNCH] <= 1'b0; // R2
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pdUnlocked   <= 1'b0;
         runPowerDown <= 1'b0;
      end else begin
         if (wrAccess && paddr == OFS_POWER_DOWN_KEY && !keyErr && pdKeyStep == 2'd1)
            pdUnlocked <= 1'b1; // R21
         if (wrAccess && paddr == OFS_ACCESS_CONTROL && pdUnlocked)
            runPowerDown <= pwdata[BIT_RUN_POWER_DOWN]; // R21
      end
   end

   // Launch: a one-cycle reset and load request
   logic launchSeen;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) launchSeen <= 1'b0;
      else launchSeen <= ctrl[BIT_OPT_LAUNCH];
   end
   assign link.optLoadStart = ctrl[BIT_OPT_LAUNCH] && !launchSeen; // R2
   assign link.devReset     = ctrl[BIT_OPT_LAUNCH] && !launchSeen; // R3

   // Memory write gating and bulk load counting
   assign needSel = bulk || ctrl[BIT_ERASE];
   always_comb begin
      if (memTargetEeprom)
         memRefused = ctrlLocked; // R17
      else
         memRefused = ctrl[BIT_CODE_LOCK] || (needSel && !ctrl[BIT_CODE_SELECT]); // R13
      if (bulk && memTargetEeprom && !ctrl[BIT_EEPROM_SELECT])
         memRefused = 1'b1; // R12
      // A start already queued counts as busy
      if (link.busy || link.opStart) memRefused = 1'b1;
   end

   logic accept;
   assign accept = memWrite && !memRefused;
   assign link.loadValid = accept && bulk && !ctrl[BIT_ERASE];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) loads <= '0;
      else if (link.loadValid) loads <= (loads + 6'd1 == loadTarget) ? 6'd0 : loads + 6'd1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.opStart    <= 1'b0;
         link.opKind     <= OP_WORD;
         link.opDualBank <= 1'b0;
         link.opEeprom   <= 1'b0;
         link.opAddr     <= '0;
         link.opData     <= '0;
      end else begin
         link.opStart <= 1'b0;
         if (accept && (!bulk || ctrl[BIT_ERASE] || loads + 6'd1 == loadTarget)) begin
            link.opStart    <= 1'b1;
            link.opDualBank <= ctrl[BIT_DUAL_BANK]; // R5
            link.opEeprom   <= memTargetEeprom;
            link.opAddr     <= memAddr;
            link.opData     <= memData;
            if (ctrl[BIT_ERASE])
               link.opKind <= memTargetEeprom ? OP_DW_ERASE : OP_PAGE_ERASE; // R8
            else if (bulk)
               link.opKind <= memTargetEeprom ? OP_DOUBLE_WORD : OP_HALF_PAGE; // R6 R7
            else if (memTargetEeprom && ctrl[BIT_FIXED_TIME])
               link.opKind <= OP_FIXED_WRITE; // R11
            else
               link.opKind <= OP_WORD;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         endFlag <= 1'b0;
         errFlag <= 1'b0;
      end else begin
         if (wrAccess && paddr == OFS_STATUS && pwdata[1]) endFlag <= 1'b0;
         if (wrAccess && paddr == OFS_STATUS && pwdata[8]) errFlag <= 1'b0;
         if (link.opDone) endFlag <= 1'b1;
         if (link.opError) errFlag <= 1'b1;
      end
   end
   assign irq = (endFlag && ctrl[BIT_END_IE]) || (errFlag && ctrl[BIT_ERR_IE]); // R23 R4

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFS_PROGRAM_ERASE_CONTROL: prdata <= ctrl;
            OFS_ACCESS_CONTROL: prdata <= 32'(runPowerDown) << BIT_RUN_POWER_DOWN;
            OFS_STATUS: prdata <= {23'h0, errFlag, 6'h0, endFlag, link.busy};
            default: prdata <= '0; // R24
         endcase
      end
   end
endmodule : nvm_ctrl_end
`default_nettype wire

// >>> design/nvm_ctrl_pkg.sv
// Function
// R1 - Control writes blocked until control key sequence
// R2 - Option-load launch holds until loading completes
// R3 - Launch ignored under option lock; causes reset
// R4 - Bit 16 end, bit 17 error interrupt enable
// R5 - Dual bank bit programs/erases both banks
// R6 - Bulk mode: 32 loads per half page
// R7 - Bulk EEPROM mode: 2 loads per double word
// R8 - Erase bit turns write into erase
// R9 - Mode bits writable only when idle
// R10 - Control lock clears mode bits; code does not clear dual bank bit 15, which takes the written value when idle
// R11 - Fixed-time write erases before EEPROM write
// R12 - Software selects EEPROM before double-word operations; code refuses only unselected bulk EEPROM writes
// R13 - Code array writes need select bit, except word
// R14 - Lock bits accept ones; keys clear them
// R15 - Bad key or third write: error, stuck lock
// R16 - Control lock sets option and code locks
// R17 - EEPROM writable only while control unlocked
// R18 - Control keys at offset 0x0C in order
// R19 - Code key accepted only after control unlock
// R20 - Code array key pair in order
// R21 - Power-down key pair unlocks run power-down
// R22 - Option key pair, needs control unlock
// R23 - End interrupt only when enable set
// R24 - Key registers read zero, store nothing
package nvm_ctrl_pkg;
   localparam logic [7:0]  OFS_ACCESS_CONTROL = 8'h00;
   localparam logic [7:0]  OFS_PROGRAM_ERASE_CONTROL = 8'h04;
   localparam logic [7:0]  OFS_POWER_DOWN_KEY = 8'h08;
   localparam logic [7:0]  OFS_CONTROL_UNLOCK_KEY = 8'h0c;
   localparam logic [7:0]  OFS_CODE_ARRAY_KEY = 8'h10;
   localparam logic [7:0]  OFS_OPTION_KEY = 8'h14;
   localparam logic [7:0]  OFS_STATUS = 8'h18;
   localparam logic [31:0] CTRL_RESET = 32'h00000007;
   localparam int BIT_CONTROL_LOCK = 0;
   localparam int BIT_CODE_LOCK = 1;
   localparam int BIT_OPTION_LOCK = 2;
   localparam int BIT_CODE_SELECT = 3;
   localparam int BIT_EEPROM_SELECT = 4;
   localparam int BIT_FIXED_TIME = 8;
   localparam int BIT_ERASE = 9;
   localparam int BIT_BULK_LOAD = 10;
   localparam int BIT_DUAL_BANK = 15;
   localparam int BIT_END_IE = 16;
   localparam int BIT_ERR_IE = 17;
   localparam int BIT_OPT_LAUNCH = 18;
   localparam int BIT_RUN_POWER_DOWN = 4;
   localparam logic [31:0] CTRL_KEY1 = 32'h89abcdef;
   localparam logic [31:0] CTRL_KEY2 = 32'h02030405;
   localparam logic [31:0] CODE_KEY1 = 32'h8c9daebf;
   localparam logic [31:0] CODE_KEY2 = 32'h13141516;
   localparam logic [31:0] PD_KEY1 = 32'h04152637;
   localparam logic [31:0] PD_KEY2 = 32'hfafbfcfd;
   localparam logic [31:0] OPT_KEY1 = 32'hfbead9c8;
   localparam logic [31:0] OPT_KEY2 = 32'h24252627;
   localparam int HALF_PAGE_LOADS = 32;
   localparam int DOUBLE_WORD_LOADS = 2;
   localparam int OP_CYCLES = 8;
   typedef enum logic [2:0] {
      OP_WORD, OP_HALF_PAGE, OP_DOUBLE_WORD, OP_PAGE_ERASE, OP_DW_ERASE, OP_FIXED_WRITE
   } op_kind_e;
endpackage : nvm_ctrl_pkg

// >>> design/nvm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvm_link_if;
   import nvm_ctrl_pkg::*;
   logic        opStart;
   op_kind_e    opKind;
   logic        opDualBank;
   logic        opEeprom;
   logic [31:0] opAddr;
   logic [31:0] opData;
   logic        loadValid;
   logic        optLoadStart;
   logic        devReset;
   logic        busy;
   logic        opDone;
   logic        opError;
   logic        optLoadDone;
   modport ctrl (output opStart, opKind, opDualBank, opEeprom, opAddr, opData, loadValid,
                 optLoadStart, devReset, input busy, opDone, opError, optLoadDone);
   modport array (input opStart, opKind, opDualBank, opEeprom, opAddr, opData, loadValid,
                  optLoadStart, devReset, output busy, opDone, opError, optLoadDone);
endinterface : nvm_link_if
`default_nettype wire

// >>> design/nvm_array_end.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array_end
   import nvm_ctrl_pkg::*;
#(
   parameter int OP_LEN = OP_CYCLES
) (
   input  wire logic  core_clk,
   input  wire logic  rst,
   nvm_link_if.array  link,
   input  wire logic  injectError,
   output logic [31:0] lastAddr,
   output logic [31:0] lastData,
   output logic [2:0]  lastKind,
   output logic        lastDual,
   output logic [7:0]  loadCount
);
   logic [15:0] timer;
   logic        optRun;
   logic        errPending;

   // Fixed-time write uses two program times
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timer <= '0;
         link.busy <= 1'b0;
         link.opDone <= 1'b0;
         link.opError <= 1'b0;
         errPending <= 1'b0;
      end else begin
         link.opDone <= 1'b0;
         link.opError <= 1'b0;
         if (link.opStart && !link.busy) begin
            link.busy <= 1'b1;
            errPending <= injectError;
            timer <= (link.opKind == OP_FIXED_WRITE) ? 16'(2 * OP_LEN) : 16'(OP_LEN); // R11
         end else if (link.busy) begin
            if (timer <= 16'h0001) begin
               link.busy <= 1'b0;
               link.opDone <= !errPending;
               link.opError <= errPending;
            end
            timer <= timer - 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lastAddr <= '0;
         lastData <= '0;
         lastKind <= '0;
         lastDual <= 1'b0;
      end else if (link.opStart && !link.busy) begin
         lastAddr <= link.opAddr;
         lastData <= link.opData;
         lastKind <= link.opKind;
         lastDual <= link.opDualBank; // R5
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         loadCount <= '0;
      end else if (link.opStart) begin
         loadCount <= '0;
      end else if (link.loadValid) begin
         loadCount <= loadCount + 8'h01; // R6 R7
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         optRun <= 1'b0;
         link.optLoadDone <= 1'b0;
      end else begin
         link.optLoadDone <= 1'b0;
         if (link.optLoadStart) begin
            optRun <= 1'b1;
         end else if (optRun) begin
            optRun <= 1'b0;
            link.optLoadDone <= 1'b1; // R2
         end
      end
   end
endmodule : nvm_array_end
`default_nettype wire

// >>> verification/nvm_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_link_sva
   import nvm_ctrl_pkg::*;
(
   input wire logic     core_clk,
   input wire logic     rst,
   input wire logic     opStart,
   input wire op_kind_e opKind,
   input wire logic     opEeprom,
   input wire logic     loadValid,
   input wire logic     optLoadStart,
   input wire logic     devReset,
   input wire logic     busy,
   input wire logic     opDone,
   input wire logic     optLoadDone
);
   logic [7:0] loads;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Loads gathered since the last start
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) loads <= 8'h00;
      else if (opStart) loads <= 8'h00;
      else if (loadValid) loads <= loads + 8'h01;
   end
   sequence run_s;
      busy [*8];
   endsequence
   sequence reload_s;
      ##[1:3] optLoadDone;
   endsequence
   start_busy_a: assert property (opStart |=> run_s)
      else $error("operation not held busy");
   start_idle_a: assert property (opStart |-> !busy)
      else $error("start while busy");
   load_idle_a: assert property (loadValid |-> !busy)
      else $error("load while busy");
   half_page_a: assert property (opStart && opKind == OP_HALF_PAGE |-> loads == 8'h20 && !opEeprom)
      else $error("half page load count wrong");
   double_word_a: assert property (opStart && opKind == OP_DOUBLE_WORD |-> loads == 8'h02 && opEeprom)
      else $error("double word load count wrong");
   dw_erase_a: assert property (opStart && opKind == OP_DW_ERASE |-> opEeprom)
      else $error("double word erase off the data array");
   fixed_time_a: assert property (opStart && opKind == OP_FIXED_WRITE |=> run_s ##8 busy)
      else $error("fixed time write too short");
   launch_reset_a: assert property (optLoadStart |-> devReset ##1 !devReset)
      else $error("launch without reset");
   launch_done_a: assert property (optLoadStart |-> reload_s)
      else $error("option load never completed");
   done_pulse_a: assert property (opDone |-> $past(busy) ##1 !opDone)
      else $error("end pulse malformed");
endmodule : nvm_link_sva
`default_nettype wire

// >>> verification/tb_nvm_program_erase_control_unlock.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_program_erase_control_unlock
   import nvm_ctrl_pkg::*;
;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} apb_s;
   typedef struct packed {logic [31:0] c; logic t; logic [5:0] n; op_kind_e k; logic inj;} op_s;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, memAddr, memData, lastAddr, lastData;
   logic        memWrite, memTargetEeprom, memRefused, irq, runPowerDown;
   logic        injectError, lastDual, opEnd;
   logic [2:0]  lastKind;
   logic [7:0]  loadCount;
   int          nErrors, cmpCount;
   apb_s rows[19] = '{
      '{1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0, 32'h00000007, 1'b0},
      '{1'b0, OFS_POWER_DOWN_KEY, 32'h0, 32'h0, 1'b0},
      '{1'b1, OFS_PROGRAM_ERASE_CONTROL, 32'h00000018, 32'h0, 1'b0},
      '{1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0, 32'h00000007, 1'b0},
      '{1'b1, OFS_CONTROL_UNLOCK_KEY, CTRL_KEY1, 32'h0, 1'b0},
      '{1'b1, OFS_CONTROL_UNLOCK_KEY, CTRL_KEY2, 32'h0, 1'b0},
      '{1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0, 32'h00000006, 1'b0},
      '{1'b1, OFS_PROGRAM_ERASE_CONTROL, 32'h00040006, 32'h0, 1'b0},
      '{1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0, 32'h00000006, 1'b0},
      '{1'b1, OFS_CODE_ARRAY_KEY, CODE_KEY1, 32'h0, 1'b0},
      '{1'b1, OFS_CODE_ARRAY_KEY, CODE_KEY2, 32'h0, 1'b0},
      '{1'b1, OFS_OPTION_KEY, OPT_KEY1, 32'h0, 1'b0},
      '{1'b1, OFS_OPTION_KEY, OPT_KEY2, 32'h0, 1'b0},
      '{1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0, 32'h0, 1'b0},
      '{1'b1, OFS_POWER_DOWN_KEY, PD_KEY1, 32'h0, 1'b0},
      '{1'b1, OFS_POWER_DOWN_KEY, PD_KEY2, 32'h0, 1'b0},
      '{1'b1, OFS_ACCESS_CONTROL, 32'h00000010, 32'h0, 1'b0},
      '{1'b0, OFS_ACCESS_CONTROL, 32'h0, 32'h00000010, 1'b0},
      '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}};
   op_s ops[6] = '{
      '{32'h00010410, 1'b1, 6'h02, OP_DOUBLE_WORD, 1'b0},
      '{32'h00008408, 1'b0, 6'h20, OP_HALF_PAGE, 1'b0},
      '{32'h00010208, 1'b0, 6'h01, OP_PAGE_ERASE, 1'b0},
      '{32'h00000210, 1'b1, 6'h01, OP_DW_ERASE, 1'b0},
      '{32'h00000100, 1'b1, 6'h01, OP_FIXED_WRITE, 1'b0},
      '{32'h00020000, 1'b0, 6'h01, OP_WORD, 1'b1}};

   nvm_link_if link();
   nvm_ctrl_end i_nvm_ctrl_end (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .memWrite(memWrite), .memTargetEeprom(memTargetEeprom),
      .memAddr(memAddr), .memData(memData), .memRefused(memRefused), .irq(irq),
      .runPowerDown(runPowerDown), .link(link));
   nvm_array_end i_nvm_array_end (.core_clk(core_clk), .rst(rst), .link(link),
      .injectError(injectError), .lastAddr(lastAddr), .lastData(lastData),
      .lastKind(lastKind), .lastDual(lastDual), .loadCount(loadCount));
   nvm_link_sva i_nvm_link_sva (.core_clk(core_clk), .rst(rst), .opStart(link.opStart),
      .opKind(link.opKind), .opEeprom(link.opEeprom), .loadValid(link.loadValid),
      .optLoadStart(link.optLoadStart), .devReset(link.devReset), .busy(link.busy),
      .opDone(link.opDone), .optLoadDone(link.optLoadDone));

   assign opEnd = link.opDone | link.opError;
   always #5 core_clk = ~core_clk;

   task automatic tally_and_finish();
      if (nErrors == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         nErrors++;
      end
   endtask : chk

   task automatic wait_hi(ref logic s);
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge core_clk);
         if (s === 1'b1) break;
      end
      if (k == 300) begin
         nErrors++;
         tally_and_finish();
      end
   endtask : wait_hi

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      wait_hi(pready);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic run_op(input op_s r);
      int i;
      apb(1'b1, OFS_PROGRAM_ERASE_CONTROL, r.c);
      injectError     <= r.inj;
      memTargetEeprom <= r.t;
      for (i = 0; i < int'(r.n); i++) begin
         @(posedge core_clk);
         memWrite <= 1'b1;
         memAddr  <= 32'(i * 4);
         memData  <= ~32'(i);
      end
      @(posedge core_clk);
      memWrite <= 1'b0;
      chk(32'(loadCount), r.c[BIT_BULK_LOAD] ? 32'(r.n) - 32'h1 : 32'h0);
      wait_hi(link.busy);
      // Mode bits flipped while running must not stick
      apb(1'b1, OFS_PROGRAM_ERASE_CONTROL, r.c ^ 32'h00008718);
      wait_hi(opEnd);
      injectError <= 1'b0;
      chk(32'(lastKind), 32'(r.k));
      chk(32'(lastDual), 32'(r.c[15]));
      chk(lastAddr, {24'h0, r.n - 6'h1, 2'h0});
      chk(lastData, ~{26'h0, r.n - 6'h1});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, r.inj ? 32'h00000100 : 32'h00000002);
      chk(32'(irq), 32'(r.inj ? r.c[17] : r.c[16]));
      apb(1'b1, OFS_STATUS, 32'h00000102);
      apb(1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0);
      chk(rd, r.c);
      chk(32'(irq), 32'h0);
   endtask : run_op

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, memWrite, memTargetEeprom, injectError} = 6'h00;
      paddr = 8'h00;
      {pwdata, memAddr, memData} = 96'h0;
      nErrors = 0;
      cmpCount = 0;
      do_reset();
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(32'(er), 32'(rows[i].err));
         if (!rows[i].w && !rows[i].err) chk(rd, rows[i].e);
      end
      chk(32'(runPowerDown), 32'h1);
      foreach (ops[i]) run_op(ops[i]);
      memTargetEeprom <= 1'b1;
      @(posedge core_clk);
      chk(32'(memRefused), 32'h0);
      apb(1'b1, OFS_PROGRAM_ERASE_CONTROL, 32'h00040000);
      apb(1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0);
      chk(rd, 32'h00040000);
      apb(1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0);
      chk(rd & 32'h00040000, 32'h0);
      apb(1'b1, OFS_PROGRAM_ERASE_CONTROL, 32'h00000719);
      apb(1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0);
      chk(rd, 32'h00000007);
      chk(32'(memRefused), 32'h1);
      do_reset();
      apb(1'b1, OFS_CODE_ARRAY_KEY, CODE_KEY1);
      chk(32'(er), 32'h1);
      apb(1'b1, OFS_CONTROL_UNLOCK_KEY, CTRL_KEY2);
      chk(32'(er), 32'h1);
      apb(1'b1, OFS_CONTROL_UNLOCK_KEY, CTRL_KEY1);
      apb(1'b1, OFS_CONTROL_UNLOCK_KEY, CTRL_KEY2);
      apb(1'b0, OFS_PROGRAM_ERASE_CONTROL, 32'h0);
      chk(rd, 32'h00000007);
      tally_and_finish();
   end
endmodule : tb_nvm_program_erase_control_unlock
`default_nettype wire
